// ---- common/npf_defs.svh ----
// Constants of the NAND page flash host controller: command bytes,
// widths, timing in ns and derived cycle counts.
// Assumes a 40 ns system clock; included by bare name.
`ifndef NPF_DEFS_SVH
`define NPF_DEFS_SVH

// ****************************************************************
// Widths and buffering
// ****************************************************************
`define NPF_DATA_W 8
`define NPF_FIFO_DEPTH 4
`define NPF_ID_LEN 12'h002
`define NPF_ST_FAIL_BIT 0

// ****************************************************************
// Command bytes
// ****************************************************************
`define NPF_CB_READ 8'h00
`define NPF_CB_READ_GO 8'h30
`define NPF_CB_ID 8'h90
`define NPF_CB_RESET 8'hff
`define NPF_CB_PROG 8'h80
`define NPF_CB_PROG_GO 8'h10
`define NPF_CB_ERASE 8'h60
`define NPF_CB_ERASE_GO 8'hd0
`define NPF_CB_STATUS 8'h70

// ****************************************************************
// Timing
// ****************************************************************
`define NPF_CLK_NS 40
`define NPF_T_RC_NS 30
`define NPF_T_RC_CYC ((`NPF_T_RC_NS + `NPF_CLK_NS - 1) / `NPF_CLK_NS)
`define NPF_RD_PH 4
`define NPF_T_R_NS 25000
`define NPF_T_R_CYC (`NPF_T_R_NS / `NPF_CLK_NS)
`define NPF_T_PROG_NS 200000
`define NPF_T_PROG_CYC ((`NPF_T_PROG_NS + `NPF_CLK_NS - 1) / `NPF_CLK_NS)
`define NPF_T_BERS_NS 2000000
`define NPF_T_BERS_CYC ((`NPF_T_BERS_NS + `NPF_CLK_NS - 1) / `NPF_CLK_NS)
`define NPF_TIMEOUT_MULT 4
`define NPF_T_WB_NS 100
`define NPF_GAP_CYC ((`NPF_T_WB_NS + `NPF_CLK_NS - 1) / `NPF_CLK_NS)
`define NPF_T_WW_NS 100
`define NPF_WP_CYC ((`NPF_T_WW_NS + `NPF_CLK_NS - 1) / `NPF_CLK_NS)

`endif

// ---- common/npf_pkg.sv ----
// Types of the NAND page flash host controller.
// Assumes nothing beyond a SystemVerilog compiler.
package npf_pkg;

  // ****************************************************************
  // Operations and controller states
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_READ,
    OP_PROG,
    OP_ERASE,
    OP_ID,
    OP_RESET
  } npf_op_type;

  typedef enum logic [3:0] {
    S_IDLE,
    S_WPSET,
    S_CMD1,
    S_ADDR,
    S_DIN,
    S_CMD2,
    S_GAP,
    S_BUSY,
    S_DOUT,
    S_DONE
  } npf_state_type;

endpackage

// ---- common/npf_stream_if.sv ----
// Valid/ready byte stream between the write FIFO and the controller.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Stream carrier
// ****************************************************************
interface npf_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

`default_nettype wire

// ---- design/npf_fifo.sv ----
// Small FIFO with registered ready and valid flags.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// FIFO
// ****************************************************************
module npf_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  npf_stream_if.src o_q
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr, next_rd;
  logic [CW-1:0] count, next_count;
  logic valid, next_valid, next_ready;
  logic push, pop;

  // Flags are registered so the source sees ready from a flop
  assign push = i_valid & o_ready;
  assign pop = valid & o_q.ready;
  assign o_q.valid = valid;
  assign o_q.data = mem[rd_ptr];

  // Pointer and level arithmetic
  always_comb begin
    next_wr = wr_ptr;
    next_rd = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr = (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd = (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10: next_count = count + CW'(1);
      2'b01: next_count = count - CW'(1);
      default: next_count = count;
    endcase
    next_ready = (next_count != CW'(D));
    next_valid = (next_count != '0);
  end

  // Storage has no reset; only the flags, pointers and level need one
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      valid <= 1'b0;
      o_ready <= 1'b1;
    end else begin
      wr_ptr <= next_wr;
      rd_ptr <= next_rd;
      count <= next_count;
      valid <= next_valid;
      o_ready <= next_ready;
    end
  end
endmodule

`default_nettype wire

// ---- design/npf_host.sv ----
// Host controller for a byte-wide NAND page flash: runs read, program,
// erase, identification and reset sequences on the device pins.
// Assumes pins are asynchronous to I_CLK_SYS and that the board
// resolves the shared I/O lines and the wired ready/busy line.
//
// What this block does
// - Host read cycle never faster than 30 ns per byte.
// - Commands, addresses, data go over eight lines with strobes.
// - Write protect held low except around program and erase.
// - Ready/busy is wired open drain; low means busy.
// - Lines are captured on write strobe rise; keep them stable.
// - Address in five cycles for read and program (two column then three row), three row for erase, one for ID; pads low.
`timescale 1ns/1ps
`default_nettype none
`include "npf_defs.svh"

module npf_host #(
  parameter int P_PROG_LIMIT = `NPF_T_PROG_CYC * `NPF_TIMEOUT_MULT,
  parameter int P_ERASE_LIMIT = `NPF_T_BERS_CYC * `NPF_TIMEOUT_MULT
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_CMD_VALID,
  input wire npf_pkg::npf_op_type I_CMD_OP,
  input wire logic [11:0] I_CMD_COL,
  input wire logic [17:0] I_CMD_ROW,
  input wire logic [11:0] I_CMD_LEN,
  output logic O_CMD_READY,
  input wire logic [7:0] I_WR_DATA,
  input wire logic I_WR_VALID,
  output logic O_WR_READY,
  output logic [7:0] O_RD_DATA,
  output logic O_RD_VALID,
  output logic O_DONE,
  output logic O_FAIL,
  output logic O_TIMEOUT,
  input wire logic [7:0] I_IO,
  output logic [7:0] O_IO,
  output logic O_IO_OE,
  output logic O_CLE,
  output logic O_ALE,
  output logic O_CE_N,
  output logic O_WE_N,
  output logic O_RE_N,
  output logic O_WP_N,
  input wire logic I_READY_BUSY_N
);
  import npf_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  npf_state_type state, next_state;
  npf_op_type op, next_op;
  logic [1:0] ph, next_ph;
  logic [19:0] cnt, next_cnt, limit;
  logic [11:0] byte_cnt, next_byte_cnt, len, next_len, out_len;
  logic [2:0] addr_idx, next_addr_idx, addr_last;
  logic [11:0] col, next_col;
  logic [17:0] row, next_row;
  logic stat, next_stat, next_fail, next_tout, next_done;
  logic next_cmd_ready, next_rd_valid, next_io_oe, next_cle, next_ale;
  logic next_ce_n, next_we_n, next_re_n, next_wp_n;
  logic [7:0] next_rd_data, next_io_out, wbyte;
  logic [7:0] io_s1, io_s2;
  logic rb_s1, rb_s2;
  logic take, wr_state, modify;

  npf_stream_if #(.W(`NPF_DATA_W)) wr_q ();

  // ****************************************************************
  // Write data buffer
  // ****************************************************************
  npf_fifo #(.W(`NPF_DATA_W), .D(`NPF_FIFO_DEPTH)) u_fifo (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_data(I_WR_DATA),
    .i_valid(I_WR_VALID),
    .o_ready(O_WR_READY),
    .o_q(wr_q)
  );
  assign wr_q.ready = take;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Two flops each; the read data and busy line are asynchronous
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      io_s1 <= 8'h00;
      io_s2 <= 8'h00;
      rb_s1 <= 1'b0;
      rb_s2 <= 1'b0;
    end else begin
      io_s1 <= I_IO;
      io_s2 <= io_s1;
      rb_s1 <= I_READY_BUSY_N;
      rb_s2 <= rb_s1;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Per-operation selections
  assign modify = (op == OP_PROG) || (op == OP_ERASE);
  assign addr_last = (op == OP_ID) ? 3'd0 : 3'd4;
  assign out_len = stat ? 12'h001 : (op == OP_ID) ? `NPF_ID_LEN : len;
  assign wr_state = (state == S_CMD1) || (state == S_CMD2) ||
                    (state == S_ADDR) || (state == S_DIN);
  assign limit = stat || (op == OP_READ) || (op == OP_ID) ?
                 20'(`NPF_T_R_CYC) :
                 (op == OP_PROG) ? 20'(P_PROG_LIMIT) :
                 20'(P_ERASE_LIMIT);

  // Byte placed on the lines during a write cycle
  always_comb begin
    wbyte = 8'h00;
    case (state)
      S_CMD1: begin
        if (stat) begin
          wbyte = `NPF_CB_STATUS;
        end else begin
          case (op)
            OP_PROG: wbyte = `NPF_CB_PROG;
            OP_ERASE: wbyte = `NPF_CB_ERASE;
            OP_ID: wbyte = `NPF_CB_ID;
            OP_RESET: wbyte = `NPF_CB_RESET;
            default: wbyte = `NPF_CB_READ;
          endcase
        end
      end
      S_CMD2: begin
        case (op)
          OP_PROG: wbyte = `NPF_CB_PROG_GO;
          OP_ERASE: wbyte = `NPF_CB_ERASE_GO;
          default: wbyte = `NPF_CB_READ_GO;
        endcase
      end
      S_ADDR: begin
        case (addr_idx)
          3'd0: wbyte = col[7:0];
          3'd1: wbyte = {4'h0, col[11:8]};
          3'd2: wbyte = row[7:0];
          3'd3: wbyte = row[15:8];
          default: wbyte = {6'h00, row[17:16]};
        endcase
      end
      S_DIN: wbyte = wr_q.data;
      default: wbyte = 8'h00;
    endcase
  end

  // Next-state logic; strobes idle and lines released by default
  always_comb begin
    next_state = state;
    next_op = op;
    next_ph = ph;
    next_cnt = cnt;
    next_byte_cnt = byte_cnt;
    next_addr_idx = addr_idx;
    next_col = col;
    next_row = row;
    next_len = len;
    next_stat = stat;
    next_fail = O_FAIL;
    next_tout = O_TIMEOUT;
    next_done = 1'b0;
    next_rd_data = O_RD_DATA;
    next_rd_valid = 1'b0;
    next_io_out = O_IO;
    next_io_oe = 1'b0;
    next_cle = 1'b0;
    next_ale = 1'b0;
    next_ce_n = O_CE_N;
    next_we_n = 1'b1;
    next_re_n = 1'b1;
    next_wp_n = O_WP_N;
    take = 1'b0;
    // Three-phase write cycle: setup, strobe low, strobe high (hold)
    if (wr_state) begin
      next_io_oe = 1'b1;
      next_cle = (state == S_CMD1) || (state == S_CMD2);
      next_ale = (state == S_ADDR);
      case (ph)
        2'd0: begin
          if ((state != S_DIN) || wr_q.valid) begin
            next_io_out = wbyte;
            next_ph = 2'd1;
            take = (state == S_DIN);
          end
        end
        2'd1: begin
          next_we_n = 1'b0;
          next_ph = 2'd2;
        end
        default: next_ph = 2'd0;
      endcase
    end
    case (state)
      S_IDLE: begin
        if (I_CMD_VALID) begin
          next_op = I_CMD_OP;
          next_col = (I_CMD_OP == OP_ID) ? 12'h000 : I_CMD_COL;
          next_row = (I_CMD_OP == OP_ID) ? 18'h0_0000 : I_CMD_ROW;
          next_len = I_CMD_LEN;
          next_stat = 1'b0;
          next_fail = 1'b0;
          next_tout = 1'b0;
          next_ph = 2'd0;
          next_cnt = 20'h0_0000;
          next_ce_n = 1'b0;
          if ((I_CMD_OP == OP_PROG) || (I_CMD_OP == OP_ERASE)) begin
            next_wp_n = 1'b1;
            next_state = S_WPSET;
          end else begin
            next_state = S_CMD1;
          end
        end
      end
      S_WPSET: begin
        // Protection released ahead of the first command byte
        if (cnt == 20'(`NPF_WP_CYC - 1)) begin
          next_cnt = 20'h0_0000;
          next_state = S_CMD1;
        end else begin
          next_cnt = cnt + 20'h0_0001;
        end
      end
      S_CMD1: begin
        if (ph == 2'd2) begin
          next_addr_idx = (op == OP_ERASE) ? 3'd2 : 3'd0;
          if (stat || (op == OP_RESET)) begin
            next_state = S_GAP;
          end else begin
            next_state = S_ADDR;
          end
        end
      end
      S_ADDR: begin
        if (ph == 2'd2) begin
          next_byte_cnt = 12'h000;
          if (addr_idx != addr_last) begin
            next_addr_idx = addr_idx + 3'd1;
          end else if (op == OP_ID) begin
            next_state = S_GAP;
          end else if ((op == OP_PROG) && (len != 12'h000)) begin
            next_state = S_DIN;
          end else begin
            next_state = S_CMD2;
          end
        end
      end
      S_DIN: begin
        if (ph == 2'd2) begin
          if (byte_cnt == len - 12'h001) begin
            next_state = S_CMD2;
          end else begin
            next_byte_cnt = byte_cnt + 12'h001;
          end
        end
      end
      S_CMD2: begin
        if (ph == 2'd2) begin
          next_state = S_GAP;
        end
      end
      S_GAP: begin
        // Busy may not show yet, and the synchroniser adds delay
        if (cnt == 20'(`NPF_GAP_CYC - 1)) begin
          next_cnt = 20'h0_0000;
          next_state = S_BUSY;
        end else begin
          next_cnt = cnt + 20'h0_0001;
        end
      end
      S_BUSY: begin
        if (rb_s2) begin
          next_cnt = 20'h0_0000;
          next_byte_cnt = 12'h000;
          next_ph = 2'd0;
          if (modify && !stat) begin
            next_stat = 1'b1;
            next_state = S_CMD1;
          end else if (op == OP_RESET) begin
            next_state = S_DONE;
          end else begin
            next_state = S_DOUT;
          end
        end else if (cnt == limit) begin
          // A hung device must not lock the controller up
          next_tout = 1'b1;
          next_state = S_DONE;
        end else begin
          next_cnt = cnt + 20'h0_0001;
        end
      end
      S_DOUT: begin
        // Four clocks per byte keeps well above the least read cycle
        case (ph)
          2'd0: begin
            if (byte_cnt == out_len) begin
              next_state = S_DONE;
            end else begin
              next_re_n = 1'b0;
              next_ph = 2'd1;
            end
          end
          2'd1: begin
            next_re_n = 1'b0;
            next_ph = 2'd2;
          end
          2'd2: next_ph = 2'd3;
          default: begin
            if (stat) begin
              next_fail = io_s2[`NPF_ST_FAIL_BIT];
            end else begin
              next_rd_data = io_s2;
              next_rd_valid = 1'b1;
            end
            next_byte_cnt = byte_cnt + 12'h001;
            next_ph = 2'd0;
          end
        endcase
      end
      S_DONE: begin
        next_done = 1'b1;
        next_ce_n = 1'b1;
        next_wp_n = 1'b0;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
    next_cmd_ready = (next_state == S_IDLE);
  end

  // State and pin registers
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state <= S_IDLE;
      op <= OP_READ;
      ph <= 2'd0;
      cnt <= 20'h0_0000;
      byte_cnt <= 12'h000;
      addr_idx <= 3'd0;
      col <= 12'h000;
      row <= 18'h0_0000;
      len <= 12'h000;
      stat <= 1'b0;
      O_FAIL <= 1'b0;
      O_TIMEOUT <= 1'b0;
      O_DONE <= 1'b0;
      O_CMD_READY <= 1'b1;
      O_RD_DATA <= 8'h00;
      O_RD_VALID <= 1'b0;
      O_IO <= 8'h00;
      O_IO_OE <= 1'b0;
      O_CLE <= 1'b0;
      O_ALE <= 1'b0;
      O_CE_N <= 1'b1;
      O_WE_N <= 1'b1;
      O_RE_N <= 1'b1;
      O_WP_N <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      ph <= next_ph;
      cnt <= next_cnt;
      byte_cnt <= next_byte_cnt;
      addr_idx <= next_addr_idx;
      col <= next_col;
      row <= next_row;
      len <= next_len;
      stat <= next_stat;
      O_FAIL <= next_fail;
      O_TIMEOUT <= next_tout;
      O_DONE <= next_done;
      O_CMD_READY <= next_cmd_ready;
      O_RD_DATA <= next_rd_data;
      O_RD_VALID <= next_rd_valid;
      O_IO <= next_io_out;
      O_IO_OE <= next_io_oe;
      O_CLE <= next_cle;
      O_ALE <= next_ale;
      O_CE_N <= next_ce_n;
      O_WE_N <= next_we_n;
      O_RE_N <= next_re_n;
      O_WP_N <= next_wp_n;
    end
  end
endmodule

`default_nettype wire

// ---- verification/npf_flash_model.sv ----
// Behavioural byte-wide NAND page device facing the host controller.
// Assumes the bench resolves the shared lines and the busy pull-up.
`timescale 1ns/1ps
`default_nettype none

// ********
// Device model
// ********
module npf_flash_model #(
  parameter int T_R_NS = 10000,
  parameter int T_PROG_NS = 200000,
  parameter int T_BERS_NS = 2000000,
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'hc3 // Arbitrary value
) (
  input wire logic i_ce_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_re_n,
  input wire logic i_wp_n,
  input wire logic [7:0] i_io,
  input wire logic i_slow,
  input wire logic i_fail,
  output logic [7:0] o_io,
  output logic o_busy = 1'b0,
  output logic o_err = 1'b0
);
  logic [7:0] mem [logic [29:0]];
  logic [7:0] pbuf [0:2111];
  logic [7:0] adr [0:4];
  logic [29:0] kq [$];
  logic [11:0] col = 12'h000;
  logic [17:0] row;
  logic [7:0] q = 8'h00;
  logic [1:0] mode = 2'h0;
  logic fail = 1'b0;
  logic drv = 1'b0;
  int na = 0;
  realtime t_re = 0.0;

  // Slow mode stretches every busy period past the host's limit
  task automatic hold_busy(input int ns);
    o_busy = 1'b1;
    #(ns * (i_slow ? 20 : 1));
    o_busy = 1'b0;
  endtask

  // Five-cycle row with its pad bits checked
  task automatic take_row5;
    row = {adr[4][1:0], adr[3], adr[2]};
    if (adr[1][7:4] != 4'h0 || adr[4][7:2] != 6'h00) o_err = 1'b1;
  endtask

  // Lines taken on write strobe rise only while selected
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_cle) begin
      if (i_io != 8'h30 && i_io != 8'h10 && i_io != 8'hd0) begin
        na = 0;
        foreach (adr[i]) adr[i] = 8'h00;
      end
      case (i_io)
        8'h90: mode = 2'h1;
        8'h70: mode = 2'h2;
        8'h30: begin
          take_row5();
          for (int i = 0; i < 2112; i++) begin
            pbuf[i] = 8'hff;
            if (mem.exists({row, 12'(i)})) pbuf[i] = mem[{row, 12'(i)}];
          end
          hold_busy(T_R_NS);
        end
        8'h10: begin
          take_row5();
          fail = i_fail || !i_wp_n;
          for (int i = 0; i < 2112 && !fail; i++) begin
            mem[{row, 12'(i)}] = pbuf[i];
          end
          hold_busy(T_PROG_NS);
        end
        8'hd0: begin
          row = {adr[2][1:0], adr[1], adr[0]};
          if (adr[2][7:2] != 6'h00) o_err = 1'b1;
          fail = i_fail || !i_wp_n;
          kq.delete();
          foreach (mem[k]) begin
            if (!fail && k[29:18] == row[17:6]) kq.push_back(k);
          end
          foreach (kq[j]) mem.delete(kq[j]);
          hold_busy(T_BERS_NS);
        end
        8'hff: hold_busy(1000);
        default: mode = 2'h0;
      endcase
    end else if (!i_ce_n && i_ale && na < 5) begin
      adr[na] = i_io;
      na = na + 1;
      col = {adr[1][3:0], adr[0]};
    end else if (!i_ce_n) begin
      pbuf[col] = i_io;
      col = col + 12'h001;
    end
  end

  // Next byte on read strobe fall; too fast a cycle is flagged
  always @(negedge i_re_n) begin
    if (!i_ce_n) begin
      if ($realtime - t_re < 30.0) o_err = 1'b1;
      t_re = $realtime;
      case (mode)
        2'h1: q = (col == 12'h000) ? MAKER_CODE : PART_CODE;
        2'h2: q = {i_wp_n, 1'b1, 5'h00, fail};
        default: q = pbuf[col];
      endcase
      col = col + 12'h001;
      drv = 1'b1;
    end
  end

  // Released lines show the inverse; chip select keeps the column
  always @(posedge i_re_n or posedge i_ce_n) drv = 1'b0;
  assign o_io = drv ? q : ~q;
endmodule

`default_nettype wire

// ---- verification/npf_host_properties.sv ----
// Concurrent checks on the host controller pins and command port.
// Assumes binding into npf_host; one clock, active-low reset.
`timescale 1ns/1ps
`default_nettype none

// ********
// Checker
// ********
module npf_host_properties (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_CMD_VALID,
  input wire logic O_CMD_READY,
  input wire logic O_DONE,
  input wire logic [7:0] O_IO,
  input wire logic O_IO_OE,
  input wire logic O_CLE,
  input wire logic O_ALE,
  input wire logic O_CE_N,
  input wire logic O_WE_N,
  input wire logic O_RE_N,
  input wire logic O_WP_N,
  input wire logic I_READY_BUSY_N
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_N);

  // Strobe shapes, qualification and idle levels
  property p_idle;
    O_CMD_READY |-> O_CE_N && !O_IO_OE && !O_WP_N;
  endproperty
  a_idle: assert property (p_idle) else $error("pins active at idle");
  property p_accept;
    I_CMD_VALID && O_CMD_READY |=> !O_CMD_READY && !O_CE_N;
  endproperty
  a_accept: assert property (p_accept) else $error("accept missed");
  property p_we_qual;
    !O_WE_N |-> O_IO_OE && !O_CE_N && O_RE_N && !(O_CLE && O_ALE);
  endproperty
  a_we_qual: assert property (p_we_qual) else $error("bad write");
  property p_we_shape;
    $fell(O_WE_N) |=> $rose(O_WE_N) ##1 O_WE_N;
  endproperty
  a_we_shape: assert property (p_we_shape) else $error("we shape");
  property p_we_hold;
    $rose(O_WE_N) |-> $stable(O_IO) && $stable(O_CLE) && $stable(O_ALE);
  endproperty
  a_we_hold: assert property (p_we_hold) else $error("lines moved");
  property p_re_shape;
    $fell(O_RE_N) |=> !O_RE_N ##1 O_RE_N [*2];
  endproperty
  a_re_shape: assert property (p_re_shape) else $error("re shape");
  property p_busy_quiet;
    (!I_READY_BUSY_N) [*3] |-> O_WE_N && O_RE_N;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("busy hit");
  property p_done;
    O_DONE |-> O_CE_N ##1 O_CMD_READY;
  endproperty
  a_done: assert property (p_done) else $error("done shape");
endmodule

bind npf_host npf_host_properties i_npf_host_properties (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_CMD_VALID(I_CMD_VALID),
  .O_CMD_READY(O_CMD_READY), .O_DONE(O_DONE), .O_IO(O_IO),
  .O_IO_OE(O_IO_OE), .O_CLE(O_CLE), .O_ALE(O_ALE), .O_CE_N(O_CE_N),
  .O_WE_N(O_WE_N), .O_RE_N(O_RE_N), .O_WP_N(O_WP_N),
  .I_READY_BUSY_N(I_READY_BUSY_N)
);

`default_nettype wire

// ---- verification/npf_host_tb.sv ----
// Self-checking bench: host controller against a behavioural device.
// Assumes the design, its package and the device model are compiled.
`timescale 1ns/1ps
`default_nettype none

// ********
// Bench
// ********
module npf_host_tb;
  import npf_pkg::*;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
  localparam logic [7:0] PART = 8'hc3; // Arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  npf_op_type cmd_op = OP_RESET;
  logic [11:0] cmd_col = 12'h000;
  logic [17:0] cmd_row = 18'h0_0000;
  logic [11:0] cmd_len = 12'h000;
  logic [7:0] wr_data = 8'h00;
  logic wr_valid = 1'b0;
  logic slow = 1'b0;
  logic inj = 1'b0;
  logic took = 1'b0;
  logic cmd_ready, wr_ready, rd_valid, done, fail, tmo, io_oe, perr;
  logic cle, ale, ce_n, we_n, re_n, wp_n, dev_busy;
  logic [7:0] rd_data, io_out, dev_io;
  logic [7:0] rd_q [$];
  logic [7:0] wr_q [$];
  int bad_count = 0;
  int cmp_count = 0;
  wire logic [7:0] io_in = io_oe ? io_out : dev_io;
  wire logic rb_n = !dev_busy;

  always #20 clk = ~clk;

  npf_host #(.P_PROG_LIMIT(200), .P_ERASE_LIMIT(400)) i_npf_host (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CMD_VALID(cmd_valid),
    .I_CMD_OP(cmd_op), .I_CMD_COL(cmd_col), .I_CMD_ROW(cmd_row),
    .I_CMD_LEN(cmd_len), .O_CMD_READY(cmd_ready), .I_WR_DATA(wr_data),
    .I_WR_VALID(wr_valid), .O_WR_READY(wr_ready), .O_RD_DATA(rd_data),
    .O_RD_VALID(rd_valid), .O_DONE(done), .O_FAIL(fail), .O_TIMEOUT(tmo),
    .I_IO(io_in), .O_IO(io_out), .O_IO_OE(io_oe), .O_CLE(cle), .O_ALE(ale),
    .O_CE_N(ce_n), .O_WE_N(we_n), .O_RE_N(re_n), .O_WP_N(wp_n),
    .I_READY_BUSY_N(rb_n)
  );
  npf_flash_model #(.T_PROG_NS(4000), .T_BERS_NS(8000), .MAKER_CODE(MAKER),
      .PART_CODE(PART)) i_npf_flash_model (
    .i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_re_n(re_n),
    .i_wp_n(wp_n), .i_io(io_in), .i_slow(slow), .i_fail(inj),
    .o_io(dev_io), .o_busy(dev_busy), .o_err(perr)
  );

  // Program bytes offered from a queue, popped once taken
  always @(posedge clk) took = wr_valid && wr_ready;
  always @(negedge clk) begin
    if (took) void'(wr_q.pop_front());
    wr_valid = (wr_q.size() != 0);
    wr_data = wr_valid ? wr_q[0] : 8'h00;
  end

  // Read bytes stand one cycle only
  always @(posedge clk) begin
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
      input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One command, offered for one cycle while ready, then a bounded wait for done
  task automatic run(input npf_op_type op, input logic [11:0] col,
      input logic [17:0] row, input logic [11:0] len);
    int n;
    rd_q.delete();
    @(negedge clk);
    chk8({7'h00, cmd_ready}, 8'h01, "ready");
    cmd_op = op;
    cmd_col = col;
    cmd_row = row;
    cmd_len = len;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 20000) begin
        bad_count++;
        $display("CHECK FAILED t=%0t no done", $time);
        wrap_up();
      end
    end
  endtask

  task automatic t_id;
    run(OP_ID, 12'h000, 18'h0_0000, 12'h000);
    chk8(8'(rd_q.size()), 8'h02, "id count");
    chk8(rd_q[0], MAKER, "maker");
    chk8(rd_q[1], PART, "part");
  endtask

  // FIFO filled to refusal, then drained by a program
  task automatic t_prog(input logic [17:0] row, input logic [7:0] seed);
    for (int i = 0; i < 6; i++) begin
      wr_q.push_back(seed + 8'(i));
    end
    repeat (10) @(negedge clk);
    chk8({7'h00, wr_ready}, 8'h00, "fifo full");
    chk8(8'(wr_q.size()), 8'h02, "fifo level");
    run(OP_PROG, 12'h000, row, 12'h006);
    chk8({6'h00, fail, tmo}, 8'h00, "prog status");
    chk8({7'h00, wr_ready}, 8'h01, "fifo empty");
  endtask

  task automatic t_read(input logic [17:0] row, input logic [11:0] col,
      input logic [11:0] len, input logic [7:0] seed, input logic ers);
    run(OP_READ, col, row, len);
    chk8(8'(rd_q.size()), len[7:0], "read count");
    foreach (rd_q[i]) begin
      chk8(rd_q[i], ers ? 8'hff : seed + col[7:0] + 8'(i), "byte");
    end
  endtask

  task automatic t_erase(input logic [17:0] row, input logic slw);
    slow = slw;
    run(OP_ERASE, 12'h000, row, 12'h000);
    chk8({6'h00, fail, tmo}, {7'h00, slw}, "erase status");
  endtask

  // Reset command, empty read, and a refused program
  task automatic t_misc;
    run(OP_RESET, 12'h000, 18'h0_0000, 12'h000);
    chk8({6'h00, fail, tmo}, 8'h00, "reset status");
    t_read(18'h0_0046, 12'h000, 12'h000, 8'h00, 1'b0);
    inj = 1'b1;
    run(OP_PROG, 12'h000, 18'h0_0007, 12'h000);
    chk8({6'h00, fail, tmo}, 8'h02, "prog fail");
    inj = 1'b0;
  endtask

  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    chk8({ce_n, we_n, re_n, wp_n, io_oe, cle, ale, done}, 8'he0, "rst");
    t_id();
    t_prog(18'h0_0005, 8'h10);
    t_prog(18'h0_0046, 8'h40);
    t_read(18'h0_0005, 12'h000, 12'h006, 8'h10, 1'b0);
    t_read(18'h0_0046, 12'h002, 12'h004, 8'h40, 1'b0);
    t_erase(18'h0_0003, 1'b0);
    t_read(18'h0_0005, 12'h000, 12'h003, 8'h00, 1'b1);
    t_read(18'h0_0046, 12'h000, 12'h002, 8'h40, 1'b0);
    t_misc();
    t_erase(18'h0_0080, 1'b1);
    chk8({7'h00, perr}, 8'h00, "pin protocol");
    wrap_up();
  end
endmodule

`default_nettype wire
